// ### pkg/tevr_pkg.sv
// Constants shared by the timing event receiver register bank
package tevr_pkg;

	// Register indices; byte address on the bus is four times the index
	localparam logic [9:0] IDX_STATUS = 10'h000;
	localparam logic [9:0] IDX_CTRL = 10'h004;
	localparam logic [9:0] IDX_FLAGS = 10'h008;
	localparam logic [9:0] IDX_IEN = 10'h00c;
	localparam logic [9:0] IDX_HWMAP = 10'h013;
	localparam logic [9:0] IDX_RXBUF = 10'h022;
	localparam logic [9:0] IDX_TXBUF = 10'h025;
	localparam logic [9:0] IDX_FWVER = 10'h02c;
	localparam logic [9:0] IDX_PRESC = 10'h042;
	localparam logic [9:0] IDX_USEC = 10'h04e;
	localparam logic [9:0] IDX_SECONDS_SHIFTER = 10'h05c;
	localparam logic [9:0] IDX_SECCNT = 10'h060;
	localparam logic [9:0] IDX_STAMP = 10'h064;
	localparam logic [9:0] IDX_SECCAP = 10'h068;
	localparam logic [9:0] IDX_STAMPCAP = 10'h06c;
	localparam logic [9:0] IDX_QSEC = 10'h070;
	localparam logic [9:0] IDX_QSTAMP = 10'h074;
	localparam logic [9:0] IDX_QCODE = 10'h07b;

	// Status word fields
	localparam int ST_BUS_LSB = 24;
	localparam int ST_ABSENT = 7;
	localparam int ST_LINK = 6;
	localparam int ST_QHALT = 5;

	// Master control fields
	localparam int CT_OWN_LOOP = 29;
	localparam int CT_LINE_LOOP = 28;
	localparam int CT_STAMP_BUS = 14;
	localparam int CT_STAMP_CLR = 13;
	localparam int CT_STAMP_CAP = 10;
	localparam int CT_RAM_ON = 9;
	localparam int CT_RAM_SEL = 8;
	localparam int CT_HIST_CLR = 7;
	localparam int CT_HIST_ON = 6;
	localparam int CT_HIST_OFF = 5;
	localparam int CT_HIST_HALT = 4;
	localparam int CT_QCLR = 3;

	// Interrupt flag and enable positions
	localparam int FL_LINK = 6;
	localparam int FL_BUF = 5;
	localparam int FL_HW = 4;
	localparam int FL_CODE = 3;
	localparam int FL_PULSE = 2;
	localparam int FL_QFULL = 1;
	localparam int FL_LINE = 0;
	localparam int FL_N = 7;
	localparam int IE_GATE = 31;

	// Receive buffer register fields
	localparam int RB_RECV = 15;
	localparam int RB_DONE = 14;
	localparam int RB_SUM = 13;
	localparam int RB_SHARE = 12;

	// Transmit buffer register fields
	localparam int TB_DONE = 20;
	localparam int TB_ACTIVE = 19;
	localparam int TB_KICK = 18;
	localparam int TB_EN = 17;
	localparam int TB_MODE = 16;
	localparam int TB_LEN_LSB = 2;

	// Distributed bus bit that may clock the stamp counter
	localparam int BUS_STAMP_BIT = 4;

	// Version word fields; identity values are arbitrary
	localparam logic [3:0] FW_KIND = 4'h_0007;
	localparam logic [2:0] FW_FORM = 3'h_0;
	localparam logic [7:0] FW_VER = 8'h_0002;

	// Microsecond derived from the 250 MHz system clock, rounded
	localparam int USEC_NS = 1000;
	localparam int CLK_PERIOD_NS = 4;
	localparam logic [15:0] USEC_CYCLES = 16'((USEC_NS + CLK_PERIOD_NS / 2) / CLK_PERIOD_NS);

	// Default answer and reset word
	localparam logic [31:0] ZERO_WORD = 32'h_0000_0000;

endpackage

// ### logic/tevr_queue_mem.sv
// Event queue storage with registered read data
`timescale 1ns/10ps
`default_nettype none

module tevr_queue_mem #(
	parameter int W = 72,
	parameter int AW = 9
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Write side
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [W-1:0] wr_data,
	// Read side
	input wire logic [AW-1:0] rd_addr,
	output logic [W-1:0] rd_data
);

	logic [W-1:0] mem [0:(1 << AW)-1];

	// Array write
	always_ff @(posedge clk_sys)
	begin
		if (wr_en)
		begin
			mem[wr_addr] <= wr_data;
		end
	end

	// Registered read every cycle
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			rd_data <= '0;
		end
		else
		begin
			rd_data <= mem[rd_addr];
		end
	end

endmodule

`default_nettype wire

// ### logic/tevr_regs.sv
// What this block does
// (RL1) Status top byte shows live bus bits
// (RL2) Status shows link up and module absent
// (RL3) Status shows event queue halted flag
// (RL4) Own transmit looped into receiver when set
// (RL5) Line receive looped to transmit when set
// (RL6) Clear strobe zeroes stamp counter and capture
// (RL7) Capture strobe copies stamp counter into capture
// (RL8) Stamp counter may tick from bus bit four
// (RL9) Decode RAM enable and RAM choice bits
// (RL10) History clear, on, off strobes, halt enable
// (RL11) Queue clear strobe empties event queue
// (RL12) Seven interrupt flags in one byte
// (RL13) Per-flag enables plus global interrupt gate
// (RL14) Interrupt only when gated and enabled flag
// (RL15) Mapped signal flag follows selected source
// (RL16) Arm starts reception, halt stops, receiving shown
// (RL17) Sum error clears on arm or halt write
// (RL18) Bus sharing bit selects half speed bus
// (RL19) Last received length in twelve bits
// (RL20) Send active from kick until done
// (RL21) Send length in four-byte steps, low zero
// (RL22) Code read pops queue head entry
// (RL23) Microsecond divider read and drives timeouts
`timescale 1ns/10ps
`default_nettype none

module tevr_regs
	import tevr_pkg::*;
#(
	parameter int QAW = 9,
	parameter int NSRC = 32,
	parameter int SYM_W = 10,
	parameter int HB_TIMEOUT_US = 1000
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	// Pins from the transceiver and bus decoder
	input wire logic [7:0] bus_bits,
	input wire logic link_up,
	input wire logic module_absent,
	// Receiver events
	input wire logic evt_valid,
	input wire logic [7:0] evt_code,
	input wire logic evt_save,
	input wire logic heartbeat_seen,
	input wire logic line_error,
	input wire logic [NSRC-1:0] map_sources,
	input wire logic [31:0] seconds_count,
	input wire logic [31:0] seconds_shifter,
	// Symbol paths
	input wire logic [SYM_W-1:0] own_tx_sym,
	input wire logic [SYM_W-1:0] line_rx_sym,
	output logic [SYM_W-1:0] rx_path_sym,
	output logic [SYM_W-1:0] line_tx_sym,
	// Data buffer engines
	input wire logic rx_buf_finished,
	input wire logic rx_buf_sum_bad,
	input wire logic [11:0] rx_buf_len,
	input wire logic send_finished,
	output logic buffer_receiving,
	output logic bus_half_speed,
	output logic send_start,
	output logic send_enable,
	output logic send_mode,
	output logic [10:0] send_length,
	// Decode and history control
	output logic decode_ram_on,
	output logic decode_ram_choice,
	output logic history_clear,
	output logic history_on,
	output logic history_off,
	output logic history_halt_on_stop_code,
	// Interrupt request
	output logic irq
);

	localparam logic [QAW:0] QDEPTH = (QAW + 1)'(1 << QAW);
	localparam logic [7:0] NSRC8 = 8'(NSRC);
	localparam logic [31:0] HB_LAST = 32'(HB_TIMEOUT_US - 1);
	localparam int QW = 72;

	typedef struct packed {
		logic [7:0] bus_s1;
		logic [7:0] bus_s2;
		logic link_s1;
		logic link_s2;
		logic link_prev;
		logic absent_s1;
		logic absent_s2;
		logic bus4_prev;
		logic own_loop;
		logic line_loop;
		logic stamp_from_bus;
		logic ram_on;
		logic ram_choice;
		logic halt_on_stop;
		logic hist_clear;
		logic hist_on;
		logic hist_off;
		logic [FL_N-1:0] flags;
		logic [FL_N-1:0] ien;
		logic gate;
		logic irq;
		logic [7:0] map_id;
		logic map_prev;
		logic rx_recv;
		logic rx_done;
		logic rx_sum_err;
		logic share;
		logic [11:0] rx_len;
		logic tx_done;
		logic tx_active;
		logic tx_en;
		logic tx_mode;
		logic [8:0] tx_len;
		logic tx_start;
		logic [15:0] presc;
		logic [15:0] presc_cnt;
		logic [31:0] stamp;
		logic [31:0] sec_cap;
		logic [31:0] stamp_cap;
		logic [QAW-1:0] q_head;
		logic [QAW-1:0] q_tail;
		logic [QAW:0] q_count;
		logic [QAW:0] q_count_lag;
		logic q_halted;
		logic [7:0] q_code;
		logic [31:0] q_sec;
		logic [31:0] q_stamp;
		logic [15:0] us_cnt;
		logic [31:0] hb_cnt;
		logic pready;
		logic [31:0] prdata;
		logic pslverr;
		logic [SYM_W-1:0] rx_path;
		logic [SYM_W-1:0] tx_path;
	} tevr_state_t;

	tevr_state_t st_q;
	tevr_state_t st_d;
	logic acc;
	logic wr;
	logic rd;
	logic [9:0] idx;
	logic push;
	logic pop;
	logic [QW-1:0] mem_rdata;

	// One wait state: access phase ends on the second penable cycle
	assign acc = psel & penable & ~st_q.pready;
	assign wr = acc & pwrite;
	assign rd = acc & ~pwrite;
	assign idx = paddr[11:2];

	// Event queue storage
	tevr_queue_mem #(
		.W(QW),
		.AW(QAW)
	) u_queue_mem (
		.clk_sys(clk_sys),
		.rst(rst),
		.wr_en(push),
		.wr_addr(st_q.q_tail),
		.wr_data({evt_code, seconds_count, st_q.stamp}),
		.rd_addr(st_q.q_head),
		.rd_data(mem_rdata)
	);

	// Next state of the whole bank
	always_comb
	begin
		logic [FL_N-1:0] fset;
		logic [FL_N-1:0] fclr;
		logic stamp_tick;
		logic us_tick;
		logic msel;
		logic q_full;
		logic [31:0] rdv;
		logic hit;
		fset = '0;
		fclr = '0;
		stamp_tick = 1'b0;
		us_tick = 1'b0;
		msel = 1'b0;
		q_full = 1'b0;
		rdv = ZERO_WORD;
		hit = 1'b1;
		st_d = st_q;
		// Pin synchronisers
		st_d.bus_s1 = bus_bits;
		st_d.bus_s2 = st_q.bus_s1;
		st_d.link_s1 = link_up;
		st_d.link_s2 = st_q.link_s1;
		st_d.link_prev = st_q.link_s2;
		st_d.absent_s1 = module_absent;
		st_d.absent_s2 = st_q.absent_s1;
		st_d.bus4_prev = st_q.bus_s2[BUS_STAMP_BIT];
		// Strobes last one cycle
		st_d.hist_clear = 1'b0;
		st_d.hist_on = 1'b0;
		st_d.hist_off = 1'b0;
		st_d.tx_start = 1'b0;
		// Symbol routing
		st_d.rx_path = st_q.own_loop ? own_tx_sym : line_rx_sym; // RL4
		st_d.tx_path = st_q.line_loop ? line_rx_sym : own_tx_sym; // RL5
		// Stamp counter clock source
		if (st_q.stamp_from_bus)
		begin
			stamp_tick = st_q.bus_s2[BUS_STAMP_BIT] & ~st_q.bus4_prev; // RL8
			st_d.presc_cnt = '0;
		end
		else if (st_q.presc_cnt >= st_q.presc)
		begin
			stamp_tick = 1'b1;
			st_d.presc_cnt = '0;
		end
		else
		begin
			st_d.presc_cnt = st_q.presc_cnt + 16'h_0001;
		end
		if (stamp_tick)
		begin
			st_d.stamp = st_q.stamp + 32'h_0000_0001;
		end
		// Microsecond tick and pulse watchdog
		us_tick = (st_q.us_cnt == USEC_CYCLES - 16'h_0001); // RL23
		st_d.us_cnt = us_tick ? '0 : st_q.us_cnt + 16'h_0001;
		if (heartbeat_seen)
		begin
			st_d.hb_cnt = '0;
		end
		else if (us_tick)
		begin
			if (st_q.hb_cnt == HB_LAST)
			begin
				fset[FL_PULSE] = 1'b1; // RL23
				st_d.hb_cnt = '0;
			end
			else
			begin
				st_d.hb_cnt = st_q.hb_cnt + 32'h_0000_0001;
			end
		end
		// Mapped signal source
		if (st_q.map_id < NSRC8)
		begin
			msel = map_sources[st_q.map_id[$clog2(NSRC)-1:0]]; // RL15
		end
		st_d.map_prev = msel;
		// Event queue fill
		q_full = (st_q.q_count == QDEPTH);
		push = evt_valid & evt_save & ~q_full & ~st_q.q_halted;
		if (evt_valid & evt_save & (q_full | st_q.q_halted))
		begin
			st_d.q_halted = 1'b1; // RL3
		end
		pop = rd & (idx == IDX_QCODE) & (st_q.q_count_lag != '0); // RL22
		if (push)
		begin
			st_d.q_tail = st_q.q_tail + 1'b1;
		end
		if (pop)
		begin
			st_d.q_head = st_q.q_head + 1'b1;
			{st_d.q_code, st_d.q_sec, st_d.q_stamp} = mem_rdata; // RL22
		end
		st_d.q_count = st_q.q_count + (QAW + 1)'(push) - (QAW + 1)'(pop);
		st_d.q_count_lag = st_q.q_count;
		// Event flag sources
		fset[FL_LINK] = st_q.link_s2 ^ st_q.link_prev;
		fset[FL_HW] = msel & ~st_q.map_prev; // RL15
		fset[FL_CODE] = evt_valid;
		fset[FL_QFULL] = push & (st_q.q_count == QDEPTH - 1'b1);
		fset[FL_LINE] = line_error;
		// Receive buffer engine completion
		if (rx_buf_finished & st_q.rx_recv)
		begin
			st_d.rx_recv = 1'b0;
			st_d.rx_done = 1'b1;
			st_d.rx_sum_err = rx_buf_sum_bad;
			st_d.rx_len = rx_buf_len; // RL19
			fset[FL_BUF] = 1'b1;
		end
		// Register writes
		if (wr)
		begin
			case (idx)
				IDX_CTRL:
				begin
					st_d.own_loop = pwdata[CT_OWN_LOOP]; // RL4
					st_d.line_loop = pwdata[CT_LINE_LOOP]; // RL5
					st_d.stamp_from_bus = pwdata[CT_STAMP_BUS]; // RL8
					st_d.ram_on = pwdata[CT_RAM_ON]; // RL9
					st_d.ram_choice = pwdata[CT_RAM_SEL]; // RL9
					st_d.hist_clear = pwdata[CT_HIST_CLR]; // RL10
					st_d.hist_on = pwdata[CT_HIST_ON]; // RL10
					st_d.hist_off = pwdata[CT_HIST_OFF]; // RL10
					st_d.halt_on_stop = pwdata[CT_HIST_HALT]; // RL10
					if (pwdata[CT_STAMP_CAP])
					begin
						st_d.stamp_cap = st_q.stamp; // RL7
						st_d.sec_cap = seconds_count;
					end
					if (pwdata[CT_STAMP_CLR])
					begin
						st_d.stamp = '0; // RL6
						st_d.stamp_cap = '0; // RL6
					end
					if (pwdata[CT_QCLR])
					begin
						st_d.q_head = '0; // RL11
						st_d.q_tail = '0;
						st_d.q_count = '0;
						st_d.q_count_lag = '0;
						st_d.q_halted = 1'b0;
					end
				end
				IDX_FLAGS: fclr = pwdata[FL_N-1:0];
				IDX_IEN:
				begin
					st_d.ien = pwdata[FL_N-1:0]; // RL13
					st_d.gate = pwdata[IE_GATE]; // RL13
				end
				IDX_HWMAP: st_d.map_id = pwdata[7:0]; // RL15
				IDX_RXBUF:
				begin
					st_d.share = pwdata[RB_SHARE]; // RL18
					if (pwdata[RB_RECV])
					begin
						st_d.rx_recv = 1'b1; // RL16
						st_d.rx_done = 1'b0;
						st_d.rx_sum_err = 1'b0; // RL17
					end
					if (pwdata[RB_DONE])
					begin
						st_d.rx_recv = 1'b0; // RL16
						st_d.rx_done = 1'b0;
						st_d.rx_sum_err = 1'b0; // RL17
					end
				end
				IDX_TXBUF:
				begin
					st_d.tx_en = pwdata[TB_EN];
					st_d.tx_mode = pwdata[TB_MODE];
					st_d.tx_len = pwdata[10:TB_LEN_LSB]; // RL21
					if (pwdata[TB_KICK] & st_q.tx_en & ~st_q.tx_active)
					begin
						st_d.tx_active = 1'b1; // RL20
						st_d.tx_done = 1'b0;
						st_d.tx_start = 1'b1;
					end
				end
				IDX_PRESC: st_d.presc = pwdata[15:0];
				default: st_d.presc = st_q.presc;
			endcase
		end
		// Send engine completion ends the active phase
		if (send_finished & st_q.tx_active)
		begin
			st_d.tx_active = 1'b0; // RL20
			st_d.tx_done = 1'b1; // RL20
		end
		// Flags: a new event wins over a clear in the same cycle
		st_d.flags = (st_q.flags & ~fclr) | fset; // RL12
		st_d.irq = st_q.gate & (|(st_q.flags & st_q.ien)); // RL14
		// Read data
		case (idx)
			IDX_STATUS:
			begin
				rdv[ST_BUS_LSB +: 8] = st_q.bus_s2; // RL1
				rdv[ST_ABSENT] = st_q.absent_s2; // RL2
				rdv[ST_LINK] = st_q.link_s2; // RL2
				rdv[ST_QHALT] = st_q.q_halted; // RL3
			end
			IDX_CTRL:
			begin
				rdv[CT_OWN_LOOP] = st_q.own_loop;
				rdv[CT_LINE_LOOP] = st_q.line_loop;
				rdv[CT_STAMP_BUS] = st_q.stamp_from_bus;
				rdv[CT_RAM_ON] = st_q.ram_on;
				rdv[CT_RAM_SEL] = st_q.ram_choice;
				rdv[CT_HIST_HALT] = st_q.halt_on_stop;
			end
			IDX_FLAGS: rdv[FL_N-1:0] = st_q.flags; // RL12
			IDX_IEN:
			begin
				rdv[FL_N-1:0] = st_q.ien;
				rdv[IE_GATE] = st_q.gate;
			end
			IDX_HWMAP: rdv[7:0] = st_q.map_id;
			IDX_RXBUF: rdv[15:0] = {st_q.rx_recv, st_q.rx_done, st_q.rx_sum_err, st_q.share,
				st_q.rx_len}; // RL19
			IDX_TXBUF: rdv[23:0] = {3'b000, st_q.tx_done, st_q.tx_active, 1'b0, st_q.tx_en,
				st_q.tx_mode, 5'b00000, st_q.tx_len, 2'b00}; // RL21
			IDX_FWVER: rdv = {FW_KIND, 1'b0, FW_FORM, 16'h_0000, FW_VER};
			IDX_PRESC: rdv[15:0] = st_q.presc;
			IDX_USEC: rdv[15:0] = USEC_CYCLES; // RL23
			IDX_SECONDS_SHIFTER: rdv = seconds_shifter;
			IDX_SECCNT: rdv = seconds_count;
			IDX_STAMP: rdv = st_q.stamp;
			IDX_SECCAP: rdv = st_q.sec_cap;
			IDX_STAMPCAP: rdv = st_q.stamp_cap;
			IDX_QSEC: rdv = st_q.q_sec;
			IDX_QSTAMP: rdv = st_q.q_stamp;
			IDX_QCODE: rdv[7:0] = pop ? mem_rdata[QW-1 -: 8] : st_q.q_code; // RL22
			default: hit = 1'b0;
		endcase
		// APB answer
		st_d.pready = acc;
		if (acc)
		begin
			st_d.pslverr = ~hit | (paddr[1:0] != 2'b00);
			st_d.prdata = (rd & hit) ? rdv : ZERO_WORD;
		end
	end

	// Whole state register
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			st_q <= '0;
		end
		else
		begin
			st_q <= st_d;
		end
	end

	// Outputs straight from state
	assign pready = st_q.pready;
	assign prdata = st_q.prdata;
	assign pslverr = st_q.pslverr;
	assign rx_path_sym = st_q.rx_path;
	assign line_tx_sym = st_q.tx_path;
	assign buffer_receiving = st_q.rx_recv;
	assign bus_half_speed = st_q.share; // RL18
	assign send_start = st_q.tx_start;
	assign send_enable = st_q.tx_en;
	assign send_mode = st_q.tx_mode;
	assign send_length = {st_q.tx_len, 2'b00};
	assign decode_ram_on = st_q.ram_on;
	assign decode_ram_choice = st_q.ram_choice;
	assign history_clear = st_q.hist_clear;
	assign history_on = st_q.hist_on;
	assign history_off = st_q.hist_off;
	assign history_halt_on_stop_code = st_q.halt_on_stop;
	assign irq = st_q.irq;

	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence s_ctrl_wr;
		wr && idx == IDX_CTRL;
	endsequence

	sequence s_kick;
		wr && idx == IDX_TXBUF && pwdata[TB_KICK] && st_q.tx_en && !st_q.tx_active;
	endsequence

	a_status_bus_top: assert property (rd && idx == IDX_STATUS |=> // RL1
		prdata[31:24] == $past(st_q.bus_s2) && pready)
		else $error("status top byte not bus bits");
	a_status_link_bit: assert property (rd && idx == IDX_STATUS |=> // RL2
		prdata[ST_LINK] == $past(st_q.link_s2) && prdata[ST_ABSENT] == $past(st_q.absent_s2))
		else $error("link or module bit wrong");
	a_own_loop_route: assert property (st_q.own_loop && !$changed(own_tx_sym) ##1 // RL4
		!$changed(own_tx_sym) |-> rx_path_sym == $past(own_tx_sym))
		else $error("loopback path not own transmit");
	a_stamp_clear_both: assert property (s_ctrl_wr ##0 pwdata[CT_STAMP_CLR] |=> // RL6
		st_q.stamp == '0 && st_q.stamp_cap == '0)
		else $error("stamp clear incomplete");
	a_stamp_capture: assert property (s_ctrl_wr ##0 pwdata[CT_STAMP_CAP] && // RL7
		!pwdata[CT_STAMP_CLR] |=> st_q.stamp_cap == $past(st_q.stamp))
		else $error("capture not equal to counter");
	a_irq_gate_off: assert property (!st_q.gate ##1 !st_q.gate |-> !irq) // RL14
		else $error("interrupt while gate closed");
	a_irq_cause: assert property (irq |-> $past(|(st_q.flags & st_q.ien))) // RL14
		else $error("interrupt without enabled flag");
	a_arm_receiving: assert property (wr && idx == IDX_RXBUF && pwdata[RB_RECV] && // RL16
		!pwdata[RB_DONE] |=> buffer_receiving && pready)
		else $error("arm did not show receiving");
	a_sum_err_clear: assert property (wr && idx == IDX_RXBUF && // RL17
		(pwdata[RB_RECV] || pwdata[RB_DONE]) |=> !st_q.rx_sum_err)
		else $error("sum error not cleared");
	a_kick_active: assert property (s_kick |=> st_q.tx_active && !st_q.tx_done && // RL20
		send_start)
		else $error("kick did not start send");
	a_pop_count: assert property (pop && !push |=> // RL22
		st_q.q_count == $past(st_q.q_count) - 1'b1)
		else $error("code read did not pop");
	a_queue_halt_hold: assert property (st_q.q_halted && !(wr && idx == IDX_CTRL && // RL3
		pwdata[CT_QCLR]) |=> st_q.q_halted)
		else $error("halted flag dropped");

endmodule

`default_nettype wire

// ### tb/tevr_partner.sv
// Upstream generator model that sends one received event code on request
`timescale 1ns/10ps
`default_nettype none

module tevr_partner (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Requests from the bench
	input wire logic go,
	input wire logic [7:0] code,
	// Decoded event toward the block
	output logic evt_valid,
	output logic [7:0] evt_code,
	output logic evt_save
);
	// One-cycle event; the code line flips to its own inverse on every idle cycle
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			evt_valid <= 1'b0;
			evt_save <= 1'b0;
			evt_code <= 8'h_00;
		end
		else
		begin
			evt_valid <= go;
			evt_save <= go;
			evt_code <= go ? code : ~evt_code;
		end
	end
endmodule

`default_nettype wire

// ### tb/tb.sv
// Self-checking bench for the event receiver register bank
`timescale 1ns/10ps
`default_nettype none

module tb;
	import tevr_pkg::*;
	`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin miscompares++; $display("wrong value t=%0t got %h exp %h", $time, g, e); end end
	logic clk_sys, rst, psel, penable, pwrite, pready, pslverr, link_up, module_absent;
	logic evt_valid, evt_save, heartbeat_seen, line_error, rx_buf_finished, rx_buf_sum_bad;
	logic send_finished, buffer_receiving, send_start, irq, ev_go;
	logic bus_half_speed, send_enable, send_mode, decode_ram_on, decode_ram_choice;
	logic history_clear, history_on, history_off, history_halt_on_stop_code;
	logic [11:0] paddr, rx_buf_len;
	logic [31:0] pwdata, prdata, map_sources, seconds_count, seconds_shifter, r;
	logic [7:0] bus_bits, evt_code, ev_code;
	logic [9:0] own_tx_sym, line_rx_sym, rx_path_sym, line_tx_sym;
	logic [10:0] send_length;
	logic e;
	int miscompares = 0;
	int check_count = 0;
	int cycles = 0;

	tevr_regs #(.QAW(3), .HB_TIMEOUT_US(2)) i_tevr_regs (.clk_sys, .rst, .psel, .penable,
		.pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .bus_bits, .link_up,
		.module_absent, .evt_valid, .evt_code, .evt_save, .heartbeat_seen, .line_error,
		.map_sources, .seconds_count, .seconds_shifter, .own_tx_sym, .line_rx_sym,
		.rx_path_sym, .line_tx_sym, .rx_buf_finished, .rx_buf_sum_bad, .rx_buf_len,
		.send_finished, .buffer_receiving, .bus_half_speed, .send_start,
		.send_enable, .send_mode, .send_length, .decode_ram_on,
		.decode_ram_choice, .history_clear, .history_on, .history_off,
		.history_halt_on_stop_code, .irq);
	tevr_partner i_tevr_partner (.clk_sys, .rst, .go(ev_go), .code(ev_code), .evt_valid,
		.evt_code, .evt_save);

	// Clock and hang guard
	initial
	begin
		clk_sys = 0;
		forever #2 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles > 5000)
		begin
			miscompares++;
			wrap_up();
		end
	end

	// One APB transfer, held until pready is seen
	task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1;
		do
		begin
			@(posedge clk_sys);
		end
		while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	// One-cycle pulse on a selected event input
	task automatic pulse(input int k);
		@(posedge clk_sys);
		case (k)
			0: line_error <= 1;
			1: ev_go <= 1;
			2: rx_buf_finished <= 1;
			default: send_finished <= 1;
		endcase
		@(posedge clk_sys);
		{line_error, ev_go, rx_buf_finished, send_finished} <= 4'b0000;
		repeat (4) @(posedge clk_sys);
	endtask

	// Status pins, divider value and an unmapped index
	task automatic t_status();
		apb(0, IDX_STATUS, 0);
		`CHK(r[31:24], 8'h_00A5)
		`CHK(r[7:6], 2'b11)
		`CHK(r[5], 1'b0)
		apb(0, IDX_USEC, 0);
		`CHK(r, 32'h_0000_00FA)
		apb(1, 10'h_0001, 32'h_FFFF_FFFF);
		`CHK(e, 1'b1)
	endtask

	// Both loopback paths
	task automatic t_loops();
		apb(1, IDX_CTRL, 32'h_2000_0000);
		repeat (2) @(posedge clk_sys);
		`CHK(rx_path_sym, own_tx_sym)
		`CHK(line_tx_sym, own_tx_sym)
		apb(1, IDX_CTRL, 32'h_1000_0000);
		repeat (2) @(posedge clk_sys);
		`CHK(rx_path_sym, line_rx_sym)
		`CHK(line_tx_sym, line_rx_sym)
		apb(1, IDX_CTRL, 32'h_0000_03F0);
		`CHK({history_clear, history_on, history_off}, 3'b111)
		`CHK({decode_ram_on, decode_ram_choice}, 2'b11)
		`CHK(history_halt_on_stop_code, 1'b1)
		@(posedge clk_sys);
		`CHK({history_clear, history_on, history_off}, 3'b000)
	endtask

	// Flag, enable, gate and clear
	task automatic t_irq();
		apb(1, IDX_IEN, 32'h_0000_0001);
		pulse(0);
		`CHK(irq, 1'b0)
		apb(1, IDX_IEN, 32'h_8000_0001);
		repeat (3) @(posedge clk_sys);
		`CHK(irq, 1'b1)
		apb(1, IDX_HWMAP, 32'h_0000_0003);
		map_sources <= 32'h_0000_0008;
		apb(0, IDX_FLAGS, 0);
		`CHK(r[FL_LINE], 1'b1)
		`CHK(r[FL_HW], 1'b1)
		apb(1, IDX_FLAGS, 32'h_0000_0001);
		repeat (3) @(posedge clk_sys);
		`CHK(irq, 1'b0)
	endtask

	// Saved event is popped by a code read
	task automatic t_queue();
		ev_code <= 8'h_003C;
		pulse(1);
		apb(0, IDX_QCODE, 0);
		`CHK(r, 32'h_0000_003C)
		apb(0, IDX_QSEC, 0);
		`CHK(r, 32'h_0000_1234)
		repeat (9) pulse(1);
		apb(0, IDX_STATUS, 0);
		`CHK(r[5], 1'b1)
		apb(0, IDX_FLAGS, 0);
		`CHK(r[FL_QFULL], 1'b1)
		apb(1, IDX_CTRL, 32'h_0000_0008);
		apb(0, IDX_STATUS, 0);
		`CHK(r[5], 1'b0)
		apb(1, IDX_CTRL, 32'h_0000_2000);
		apb(1, IDX_CTRL, 32'h_0000_0400);
		apb(0, IDX_STAMPCAP, 0);
		`CHK(r, 32'h_0000_0003)
		apb(1, IDX_CTRL, 32'h_0000_2000);
		apb(0, IDX_STAMPCAP, 0);
		`CHK(r, 32'h_0000_0000)
	endtask

	// Receive buffer arm, finish with bad sum, then clear
	task automatic t_rxbuf();
		apb(1, IDX_RXBUF, 32'h_0000_9000);
		`CHK(buffer_receiving, 1'b1)
		`CHK(bus_half_speed, 1'b1)
		apb(1, IDX_RXBUF, 32'h_0000_4000);
		`CHK(buffer_receiving, 1'b0)
		apb(1, IDX_RXBUF, 32'h_0000_9000);
		rx_buf_len <= 12'h_0123;
		rx_buf_sum_bad <= 1;
		pulse(2);
		apb(0, IDX_RXBUF, 0);
		`CHK(r[13:0], 14'h_3123)
		apb(1, IDX_RXBUF, 32'h_0000_4000);
		apb(0, IDX_RXBUF, 0);
		`CHK(r[13], 1'b0)
	endtask

	// Transmit enable, kick, running and done
	task automatic t_tx();
		apb(1, IDX_TXBUF, 32'h_0003_0010);
		`CHK({send_enable, send_mode}, 2'b11)
		apb(1, IDX_TXBUF, 32'h_0007_0010);
		`CHK(send_start, 1'b1)
		repeat (2) @(posedge clk_sys);
		`CHK(send_length, 11'h_010)
		apb(0, IDX_TXBUF, 0);
		`CHK(r[20:19], 2'b01)
		pulse(3);
		apb(0, IDX_TXBUF, 0);
		`CHK(r[20:19], 2'b10)
	endtask

	// Verdict and end of run
	task automatic wrap_up();
		$display("miscompares %0d check_count %0d", miscompares, check_count);
		if (miscompares == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Main sequence
	initial
	begin
		{rst, psel, penable, pwrite, line_error, rx_buf_finished, ev_go} = 7'b1000000;
		{rx_buf_sum_bad, send_finished, heartbeat_seen} = 3'b000;
		{paddr, pwdata, rx_buf_len, ev_code, map_sources} = '0;
		{seconds_count, seconds_shifter} = {32'h_0000_1234, 32'h_0000_0000};
		{bus_bits, link_up, module_absent} = {8'h_00A5, 2'b11};
		{own_tx_sym, line_rx_sym} = {10'h_02AA, 10'h_0155};
		repeat (2) @(posedge clk_sys);
		rst <= 0;
		t_status();
		t_loops();
		t_irq();
		t_queue();
		t_rxbuf();
		t_tx();
		wrap_up();
	end
endmodule

`default_nettype wire
